//--- ext_bus_map.vh
// Constants for the external bus and pin control block
// Function
// - Branch on test zero pin level
// - Clock-out instruction turns test zero into output
// - Branch on test one; counter-start counts it
// - Stop-mode wake waits for reset release
// - Single-step input runs one step at once
// - Interrupt only when enabled; reset disables
// - Branch on interrupt pin level
// - External access forces external program fetch
// - Address latch strobe pulses every machine cycle; held low while reset pin is low and in stop mode
// - Fetch drives low address, then fetch strobe
// - Fetch strobe only for program fetches
// - Data access: address, then read/write strobe
// - Read strobe reads, write strobe writes
// - Port two low nibble carries high address on external fetches only
// - Port two low nibble expander bus, pulsed
// - Two 8-bit quasi-bidirectional software ports
// - Oscillator pin low at reset enables stop
// - Bus output holds until reset or move; an external fetch overwrites it with the fetch low address
`ifndef EXT_BUS_MAP_VH
`define EXT_BUS_MAP_VH
// Machine cycle of fifteen clocks, split into five states of three
`define CYC_LEN 4'd15
`define ST_ADDR 4'd0
`define ST_ALE_END 4'd3
`define ST_FLOAT 4'd5
`define ST_STB_ON 4'd6
`define ST_STB_OFF 4'd12
`define ST_LAST 4'd14
// Reset length in machine cycles
`define RST_CYCLES 3'd5
// Command codes from the core
`define CMD_NONE 4'h0
`define CMD_FETCH 4'h1
`define CMD_XRD 4'h2
`define CMD_XWR 4'h3
`define CMD_OUTBUS 4'h4
`define CMD_P1WR 4'h5
`define CMD_P2WR 4'h6
`define CMD_EXPWR 4'h7
`define CMD_EXPRD 4'h8
`define CMD_CLKOUT 4'h9
`define CMD_CNTSTART 4'ha
`define CMD_CNTSTOP 4'hb
`define CMD_INTEN 4'hc
`define CMD_INTDIS 4'hd
`define CMD_STOP 4'he
// Branch condition codes
`define BR_T0 3'd0
`define BR_NT0 3'd1
`define BR_T1 3'd2
`define BR_NT1 3'd3
`define BR_NI 3'd4
// Reset values
`define PORT_RST 8'hff
`endif

//--- ext_bus.v
// External bus, pin control and test/interrupt logic of the microcomputer
`default_nettype none
`include "ext_bus_map.vh"

module ext_bus (
  // Clock and reset
  input wire core_clk,
  input wire rst,
  // Device pins, inputs
  input wire reset_pin_n,
  input wire single_step_n,
  input wire int_pin_n,
  input wire external_access_select,
  input wire osc_control,
  input wire test_one_pin,
  input wire test_zero_in,
  // Device pins, outputs
  output reg test_zero_out,
  output reg test_zero_oe,
  output reg ale,
  output reg program_fetch_strobe_n,
  output reg rd_n,
  output reg wr_n,
  output reg expander_pulse,
  // Data bus, three signals
  input wire [7:0] data_bus_in,
  output reg [7:0] data_bus_out,
  output reg data_bus_oe,
  // Quasi ports: output latch drives low strongly, high weakly
  input wire [7:0] port_one_in,
  output reg [7:0] quasi_port_one,
  input wire [7:0] port_two_in,
  output reg [7:0] quasi_port_two,
  // Core command side
  input wire [3:0] cmd,
  input wire [11:0] cmd_addr,
  input wire [7:0] cmd_data,
  input wire [2:0] br_sel,
  input wire pc_in_internal,
  output reg cmd_ready,
  output reg [7:0] rd_data,
  output reg rd_valid,
  output reg br_taken,
  output reg int_request,
  output reg count_pulse,
  output reg step_enable,
  output reg stop_mode,
  output reg cpu_run
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  localparam S_IDLE = 3'b001; // No external cycle
  localparam S_BUSY = 3'b010; // External cycle running
  localparam S_STOP = 3'b100; // Oscillator stopped
  reg [2:0] state; // One-hot controller state
  reg [3:0] phase; // Clock within machine cycle
  reg [3:0] op; // Captured command
  reg [11:0] addr; // Captured address
  reg [7:0] wdata; // Captured write data
  reg bus_hold; // Bus kept driving after output instruction
  reg int_enable; // External interrupt enable
  reg clk_out_en; // Test zero clock output mode
  reg counting; // Event counter source enabled
  reg t1_last; // Previous test one level
  reg stop_allowed; // Stop mode strapped at reset
  reg rst_pin_last; // Previous reset pin level
  reg [2:0] rst_cnt; // Machine cycles of reset held
  reg ss_last; // Previous single-step level
  reg clk_div; // Divided clock for test zero output
  wire cycle_end; // Last clock of machine cycle
  wire ext_fetch; // Fetch goes to external memory

  assign cycle_end = (phase == `ST_LAST);
  // External access forces all fetches outward
  assign ext_fetch = external_access_select | ~pc_in_internal;

  // Branch condition evaluation
  function br_eval;
    input [2:0] sel;
    input t0;
    input t1;
    input in_n;
    begin
      case (sel)
        `BR_T0: br_eval = t0;
        `BR_NT0: br_eval = ~t0;
        `BR_T1: br_eval = t1;
        `BR_NT1: br_eval = ~t1;
        `BR_NI: br_eval = ~in_n;
        default: br_eval = 1'b0;
      endcase
    end
  endfunction

  // ----------------------------------------
  // Machine cycle timebase and reset pin
  // ----------------------------------------
  // Phase counter runs every machine cycle, held at zero only by rst or stop mode
  always @(posedge core_clk) begin
    if (rst || state == S_STOP)
      phase <= 4'h0;
    else if (cycle_end)
      phase <= 4'h0;
    else
      phase <= phase + 4'h1;
  end

  // Reset pin: count cycles held low, strap oscillator control
  always @(posedge core_clk) begin
    if (rst) begin
      rst_cnt <= 3'd0;
      rst_pin_last <= 1'b1;
      stop_allowed <= 1'b0;
      cpu_run <= 1'b0;
    end else begin
      rst_pin_last <= reset_pin_n;
      if (!reset_pin_n) begin
        cpu_run <= 1'b0;
        stop_allowed <= ~osc_control;
        if (cycle_end && rst_cnt != `RST_CYCLES)
          rst_cnt <= rst_cnt + 3'd1;
      end else begin
        // Run only after a reset held long enough
        if (!rst_pin_last && rst_cnt == `RST_CYCLES)
          cpu_run <= 1'b1;
        rst_cnt <= 3'd0;
      end
    end
  end

  // ----------------------------------------
  // Bus controller
  // ----------------------------------------
  // Runs one external machine cycle per accepted command
  always @(posedge core_clk) begin
    if (rst || !reset_pin_n) begin
      state <= S_IDLE;
      op <= `CMD_NONE;
      addr <= 12'h000;
      wdata <= 8'h00;
      bus_hold <= 1'b0;
      int_enable <= 1'b0;
      clk_out_en <= 1'b0;
      counting <= 1'b0;
      stop_mode <= 1'b0;
      quasi_port_one <= `PORT_RST;
      quasi_port_two <= `PORT_RST;
      data_bus_out <= 8'h00;
      data_bus_oe <= 1'b0;
      ale <= 1'b0;
      program_fetch_strobe_n <= 1'b1;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      expander_pulse <= 1'b0;
      cmd_ready <= 1'b0;
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= 1'b0;
      cmd_ready <= 1'b0;
      // Latch strobe every cycle, ended before any strobe
      // High for the first three clocks, so the address has settled by its fall
      if (state != S_STOP)
        ale <= (phase == `ST_LAST) || (phase < `ST_ALE_END - 4'd1);
      case (state)
        S_IDLE: begin
          if (cycle_end && cpu_run && cmd != `CMD_NONE) begin
            op <= cmd;
            addr <= cmd_addr;
            wdata <= cmd_data;
            state <= S_BUSY;
            case (cmd)
              `CMD_FETCH: begin
                if (ext_fetch) begin
                  data_bus_out <= cmd_addr[7:0];
                  data_bus_oe <= 1'b1;
                  quasi_port_two[3:0] <= cmd_addr[11:8];
                end
              end
              `CMD_XRD, `CMD_XWR: begin
                data_bus_out <= cmd_addr[7:0];
                data_bus_oe <= 1'b1;
                bus_hold <= 1'b0;
              end
              `CMD_EXPWR, `CMD_EXPRD: begin
                quasi_port_two[3:0] <= cmd_addr[3:0];
              end
              default: begin
              end
            endcase
          end
        end
        S_BUSY: begin
          // Release address before a read strobe; an external fetch keeps driving while bus output is held
          if (phase == `ST_FLOAT && (op == `CMD_XRD || (op == `CMD_FETCH && ext_fetch)))
            data_bus_oe <= bus_hold;
          if (phase == `ST_FLOAT && op == `CMD_XWR)
            data_bus_out <= wdata;
          if (phase == `ST_STB_ON) begin
            case (op)
              `CMD_FETCH: program_fetch_strobe_n <= ~ext_fetch;
              `CMD_XRD: rd_n <= 1'b0;
              `CMD_XWR: wr_n <= 1'b0;
              `CMD_EXPWR: begin
                expander_pulse <= 1'b1;
                quasi_port_two[3:0] <= wdata[3:0];
              end
              `CMD_EXPRD: begin
                expander_pulse <= 1'b1;
                quasi_port_two[3:0] <= 4'hf;
              end
              default: begin
              end
            endcase
          end
          if (phase == `ST_STB_OFF) begin
            // Capture read data at strobe end
            if (op == `CMD_FETCH && ext_fetch)
              rd_data <= data_bus_in;
            else if (op == `CMD_XRD)
              rd_data <= data_bus_in;
            else if (op == `CMD_EXPRD)
              rd_data <= {4'h0, port_two_in[3:0]};
            program_fetch_strobe_n <= 1'b1;
            rd_n <= 1'b1;
            wr_n <= 1'b1;
            expander_pulse <= 1'b0;
          end
          if (cycle_end) begin
            case (op)
              `CMD_OUTBUS: begin
                data_bus_out <= wdata;
                bus_hold <= 1'b1;
              end
              `CMD_P1WR: quasi_port_one <= wdata;
              `CMD_P2WR: quasi_port_two <= wdata;
              `CMD_CLKOUT: clk_out_en <= 1'b1;
              `CMD_CNTSTART: counting <= 1'b1;
              `CMD_CNTSTOP: counting <= 1'b0;
              `CMD_INTEN: int_enable <= 1'b1;
              `CMD_INTDIS: int_enable <= 1'b0;
              default: begin
              end
            endcase
            data_bus_oe <= bus_hold || op == `CMD_OUTBUS;
            rd_valid <= (op == `CMD_FETCH) || (op == `CMD_XRD) || (op == `CMD_EXPRD);
            cmd_ready <= 1'b1;
            if (op == `CMD_STOP && stop_allowed) begin
              stop_mode <= 1'b1;
              state <= S_STOP;
              // No latch pulse once the oscillator stops; this also avoids
              // a lone one-clock strobe on the entry edge
              ale <= 1'b0;
            end else begin
              state <= S_IDLE;
            end
          end
        end
        S_STOP: begin
          // Wake only through reset pin release, handled above
          ale <= 1'b0;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Test pins, interrupt, single step
  // ----------------------------------------
  // Test zero clock output, counter edge, interrupt and step gating
  always @(posedge core_clk) begin
    if (rst) begin
      clk_div <= 1'b0;
      test_zero_out <= 1'b0;
      test_zero_oe <= 1'b0;
      t1_last <= 1'b0;
      count_pulse <= 1'b0;
      int_request <= 1'b0;
      br_taken <= 1'b0;
      ss_last <= 1'b1;
      step_enable <= 1'b0;
    end else begin
      clk_div <= ~clk_div;
      test_zero_out <= clk_div;
      test_zero_oe <= clk_out_en;
      t1_last <= test_one_pin;
      count_pulse <= counting & t1_last & ~test_one_pin;
      int_request <= int_enable & ~int_pin_n & cpu_run;
      br_taken <= br_eval(br_sel, test_zero_in, test_one_pin, int_pin_n);
      ss_last <= single_step_n;
      // One step per falling edge of single step while asserted
      if (!single_step_n)
        step_enable <= ss_last & cpu_run;
      else
        step_enable <= cpu_run;
    end
  end

endmodule // ext_bus
`default_nettype wire

//--- ext_bus_props.sv
// Assertion checker for the external bus block ports
`default_nettype none
`include "ext_bus_map.vh"
module ext_bus_props (
  // Clock, reset and pins
  input wire logic core_clk,
  input wire logic rst,
  input wire logic reset_pin_n,
  input wire logic int_pin_n,
  input wire logic test_zero_in,
  input wire logic test_one_pin,
  input wire logic [2:0] br_sel,
  // Bus strobes
  input wire logic ale,
  input wire logic program_fetch_strobe_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic data_bus_oe,
  // Status outputs
  input wire logic test_zero_out,
  input wire logic test_zero_oe,
  input wire logic br_taken,
  input wire logic int_request,
  input wire logic count_pulse,
  input wire logic cpu_run
);
  timeunit 1ns;
  timeprecision 1ns;
  logic exp_br;
  logic past_ok;
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (rst);
  // Branch outcome expected one clock after the select
  always @(posedge core_clk) begin
    past_ok <= !rst && reset_pin_n && br_sel <= `BR_NI;
    exp_br <= br_sel[2] ? !int_pin_n : (br_sel[1] ? test_one_pin : test_zero_in) ^ br_sel[0];
  end
  a_fetch_only: assert property (!program_fetch_strobe_n |-> rd_n && wr_n)
    else $error("fetch strobe with data strobe");
  a_strobe_len: assert property ($fell(program_fetch_strobe_n) |->
    !program_fetch_strobe_n [*5] ##[1:2] program_fetch_strobe_n) else $error("bad strobe");
  a_ale_pulse: assert property ($rose(ale) && $past(cpu_run) |-> ale [*3] ##1 !ale [*8])
    else $error("bad latch pulse");
  a_addr_float: assert property ($fell(program_fetch_strobe_n) || $fell(rd_n) |->
    !ale && !$past(ale) && !data_bus_oe) else $error("address not floated");
  a_wr_data: assert property (!wr_n |-> data_bus_oe)
    else $error("write without data");
  a_branch_cond: assert property (past_ok |-> br_taken == exp_br)
    else $error("wrong branch result");
  a_int_quiet: assert property (int_pin_n && $past(int_pin_n) |-> !int_request)
    else $error("interrupt without pin");
  a_clk_out: assert property (test_zero_oe && $past(test_zero_oe) |->
    test_zero_out != $past(test_zero_out)) else $error("clock out stuck");
  a_count_edge: assert property (count_pulse |-> !$past(test_one_pin))
    else $error("count without falling input");
endmodule // ext_bus_props
`default_nettype wire

//--- ext_mem_model.sv
// Behavioural external program and data memory
`default_nettype none
module ext_mem (
  // Clock and bus pins
  input wire logic core_clk,
  input wire logic ale,
  input wire logic program_fetch_strobe_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [7:0] data_bus_out,
  input wire logic [7:0] quasi_port_two,
  // Data returned onto the bus
  output logic [7:0] mem_q
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [11:0] addr;
  logic [7:0] ram [256];
  logic ale_d;
  initial mem_q = 8'h00;
  // Latch address after latch strobe, answer under strobes, scramble when released
  always @(posedge core_clk) begin
    ale_d <= ale;
    if (ale_d && !ale) addr <= {quasi_port_two[3:0], data_bus_out};
    if (!wr_n) ram[addr[7:0]] <= data_bus_out;
    if (!program_fetch_strobe_n) mem_q <= addr[7:0] ^ {2{addr[11:8]}};
    else if (!rd_n) mem_q <= ram[addr[7:0]];
    else mem_q <= ~mem_q;
  end
endmodule // ext_mem
`default_nettype wire

//--- testbench.sv
// Self-checking bench for the external bus block
`default_nettype none
`include "ext_bus_map.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 0, rst = 1, reset_pin_n = 0, single_step_n = 1, int_pin_n = 1;
  logic external_access_select = 1, osc_control = 0, test_one_pin = 0, t0_drv = 0;
  logic [3:0] cmd = 0;
  logic [11:0] cmd_addr = 0;
  logic [7:0] cmd_data = 0, got;
  logic [2:0] br_sel = 0;
  logic pc_in_internal = 1, s_f, s_r, s_w, s_p;
  wire logic test_zero_out, test_zero_oe, ale, program_fetch_strobe_n, rd_n, wr_n;
  wire logic expander_pulse, data_bus_oe, cmd_ready, rd_valid, br_taken, int_request;
  wire logic count_pulse, step_enable, stop_mode, cpu_run, test_zero_in;
  wire logic [7:0] data_bus_out, quasi_port_one, quasi_port_two, rd_data, mem_q;
  wire logic [7:0] port_one_in = quasi_port_one, port_two_in = quasi_port_two;
  wire logic [7:0] data_bus_in = data_bus_oe ? data_bus_out : mem_q;
  int errors = 0, samples_checked = 0;
  assign test_zero_in = test_zero_oe ? test_zero_out : t0_drv;
  ext_bus dut (
    .core_clk(core_clk), .rst(rst), .reset_pin_n(reset_pin_n),
    .single_step_n(single_step_n), .int_pin_n(int_pin_n),
    .external_access_select(external_access_select), .osc_control(osc_control),
    .test_one_pin(test_one_pin), .test_zero_in(test_zero_in),
    .test_zero_out(test_zero_out), .test_zero_oe(test_zero_oe), .ale(ale),
    .program_fetch_strobe_n(program_fetch_strobe_n), .rd_n(rd_n), .wr_n(wr_n),
    .expander_pulse(expander_pulse), .data_bus_in(data_bus_in),
    .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe),
    .port_one_in(port_one_in), .quasi_port_one(quasi_port_one),
    .port_two_in(port_two_in), .quasi_port_two(quasi_port_two),
    .cmd(cmd), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .br_sel(br_sel),
    .pc_in_internal(pc_in_internal), .cmd_ready(cmd_ready), .rd_data(rd_data),
    .rd_valid(rd_valid), .br_taken(br_taken), .int_request(int_request),
    .count_pulse(count_pulse), .step_enable(step_enable), .stop_mode(stop_mode),
    .cpu_run(cpu_run)
  );
  ext_mem mem (
    .core_clk(core_clk), .ale(ale), .program_fetch_strobe_n(program_fetch_strobe_n),
    .rd_n(rd_n), .wr_n(wr_n), .data_bus_out(data_bus_out),
    .quasi_port_two(quasi_port_two), .mem_q(mem_q)
  );
  always #25 core_clk = ~core_clk;
  // Strobes seen during a command
  always @(posedge core_clk) begin
    if (!program_fetch_strobe_n) s_f <= 1;
    if (!rd_n) s_r <= 1;
    if (!wr_n) s_w <= 1;
    if (expander_pulse) s_p <= 1;
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic final_report;
    if (errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic issue(input logic [3:0] c, input logic [11:0] a, input logic [7:0] d);
    int n;
    logic rd_exp;
    {s_f, s_r, s_w, s_p} = 0;
    cmd = c;
    cmd_addr = a;
    cmd_data = d;
    n = 0;
    do begin
      tick(1);
      n++;
    end while (cmd_ready !== 1 && n < 40);
    got = rd_data;
    rd_exp = (c == `CMD_FETCH) || (c == `CMD_XRD) || (c == `CMD_EXPRD);
    cmd = `CMD_NONE;
    chk("cmd_ready", 1, n < 40);
    chk("rd_valid", rd_exp, rd_valid);
    if (n == 40) final_report();
  endtask
  task automatic wait_flag(input string nm, input bit sel);
    int n;
    for (n = 0; n < 40 && (sel ? step_enable : count_pulse) !== 1; n++) @(posedge core_clk) #1;
    chk(nm, 1, n < 40);
    if (n == 40) final_report();
    else tick(1);
  endtask
  task automatic pin_reset(input int len);
    reset_pin_n = 0;
    tick(len);
    reset_pin_n = 1;
    tick(2);
  endtask
  task automatic branches;
    logic v;
    for (int i = 0; i < 10; i++) begin
      v = i[0];
      br_sel = 3'(i / 2);
      t0_drv = v;
      test_one_pin = v;
      int_pin_n = v;
      tick(2);
      chk("br_taken", (i < 8 && !i[1]) ? v : !v, br_taken);
      chk("int_request", 0, int_request);
    end
    int_pin_n = 1;
  endtask
  // Reset release after a long enough pin reset
  task automatic reset_start;
    tick(6);
    rst = 0;
    pin_reset(80);
    chk("cpu_run", 1, cpu_run);
    chk("port_one", 8'hff, quasi_port_one);
  endtask
  // External fetch, internal fetch, data write and read
  task automatic bus_cycles;
    issue(`CMD_FETCH, 12'ha5c, 0);
    chk("fetch", 8'hf6, got);
    chk("fetch_strobe", 1, s_f & !s_r);
    external_access_select = 0;
    issue(`CMD_FETCH, 12'h123, 0);
    chk("internal_fetch", 0, s_f);
    external_access_select = 1;
    issue(`CMD_XWR, 12'h03c, 8'h96);
    chk("write", 1, s_w & !s_f);
    issue(`CMD_XRD, 12'h03c, 0);
    chk("read", 8'h96, got);
  endtask
  // Bus output held until an external move
  task automatic bus_hold_out;
    issue(`CMD_OUTBUS, 0, 8'h3a);
    tick(30);
    chk("bus_out", 8'h3a, data_bus_out);
    chk("bus_oe", 1, data_bus_oe);
    issue(`CMD_XRD, 12'h03c, 0);
    tick(20);
    chk("bus_oe", 0, data_bus_oe);
  endtask
  // Port latches and expander transfers
  task automatic ports_expander;
    issue(`CMD_P1WR, 0, 8'h5a);
    issue(`CMD_P2WR, 0, 8'ha3);
    chk("port_one", 8'h5a, quasi_port_one);
    chk("port_two", 8'ha3, quasi_port_two);
    issue(`CMD_EXPWR, 0, 8'h07);
    chk("expander", 1, s_p);
    issue(`CMD_EXPRD, 0, 8'h05);
    chk("expander", 1, s_p);
    chk("exp_read", 8'h0f, got);
  endtask
  // Interrupt enable, clock output, counter input and single step
  task automatic pin_functions;
    issue(`CMD_INTEN, 0, 0);
    int_pin_n = 0;
    tick(3);
    chk("int_on", 1, int_request);
    issue(`CMD_INTDIS, 0, 0);
    tick(2);
    chk("int_off", 0, int_request);
    issue(`CMD_CLKOUT, 0, 0);
    tick(2);
    chk("t0_oe", 1, test_zero_oe);
    issue(`CMD_CNTSTART, 0, 0);
    test_one_pin = 1;
    tick(3);
    test_one_pin = 0;
    wait_flag("count", 0);
    issue(`CMD_CNTSTOP, 0, 0);
    single_step_n = 0;
    tick(3);
    chk("step_hold", 0, step_enable);
    single_step_n = 1;
    wait_flag("step", 1);
  endtask
  // Short reset, interrupt after reset, stop entry and wake
  task automatic reset_and_stop;
    pin_reset(60);
    chk("short_reset", 0, cpu_run);
    pin_reset(80);
    tick(3);
    chk("int_after_reset", 0, int_request);
    int_pin_n = 1;
    issue(`CMD_STOP, 0, 0);
    tick(2);
    chk("stop", 1, stop_mode);
    pin_reset(80);
    chk("stop_exit", 0, stop_mode);
    chk("wake", 1, cpu_run);
  endtask
  initial begin
    reset_start();
    branches();
    bus_cycles();
    bus_hold_out();
    ports_expander();
    pin_functions();
    reset_and_stop();
    final_report();
  end
endmodule // testbench
bind ext_bus ext_bus_props u_props (
  .core_clk(core_clk), .rst(rst), .reset_pin_n(reset_pin_n), .int_pin_n(int_pin_n),
  .test_zero_in(test_zero_in), .test_one_pin(test_one_pin), .br_sel(br_sel),
  .ale(ale), .program_fetch_strobe_n(program_fetch_strobe_n), .rd_n(rd_n),
  .wr_n(wr_n), .data_bus_oe(data_bus_oe), .test_zero_out(test_zero_out),
  .test_zero_oe(test_zero_oe), .br_taken(br_taken), .int_request(int_request),
  .count_pulse(count_pulse), .cpu_run(cpu_run)
);
`default_nettype wire
